// >>> hw/mrr_measurement_regs.v
// Read-side register bank for the measurement results and the die identification byte.
`default_nettype none
`include "mrr_consts.vh"
module mrr_measurement_regs #(
  parameter [1:0] SITE_CODE      = 2'h1, // Arbitrary value.
  parameter [1:0] MAJOR_REVISION = 2'h1, // Arbitrary value.
  parameter [1:0] MINOR_REVISION = 2'h1, // Arbitrary value.
  parameter [1:0] MAKER_CODE     = 2'h2  // Arbitrary value.
) (
  input  wire       core_clk_i,
  input  wire       reset_i,
  input  wire [7:0] reg_addr_i,
  input  wire [7:0] reg_wdata_i,
  input  wire       reg_write_i,
  input  wire       reg_read_i,
  output reg  [7:0] reg_rdata_o,
  input  wire [8:0] port3_pin_voltage_count_i,
  input  wire [8:0] port4_current_count_i,
  input  wire [8:0] port4_pin_voltage_count_i,
  input  wire [8:0] supply_voltage_count_i,
  input  wire [8:0] die_temperature_count_i,
  input  wire [8:0] power_limit_count_i,
  input  wire       result_update_i
);
  reg  [8:0] p3v_r;
  reg  [8:0] p4i_r;
  reg  [8:0] p4v_r;
  reg  [8:0] vin_r;
  reg  [8:0] temp_r;
  wire [8:0] pwr_w;
  wire [7:0] die_identification_w;
  reg  [7:0] rdata_nxt;

  function [7:0] low_byte;
    input [8:0] count;
    begin
      low_byte = {7'h00, count[0]};
    end
  endfunction

  function [7:0] high_byte;
    input [8:0] count;
    begin
      high_byte = count[8:1];
    end
  endfunction

  mrr_power_latch #(
    .WIDTH(`MRR_COUNT_W)
  ) u_power_latch (
    .core_clk_i          (core_clk_i),
    .reset_i             (reset_i),
    .power_limit_count_i (power_limit_count_i),
    .power_limit_count_o (pwr_w)
  );

  // Results are refreshed together, but each byte is read on its own, so an update between two reads mixes two conversions.
  always @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      p3v_r  <= `MRR_COUNT_RST;
      p4i_r  <= `MRR_COUNT_RST;
      p4v_r  <= `MRR_COUNT_RST;
      vin_r  <= `MRR_COUNT_RST;
      temp_r <= `MRR_COUNT_RST;
    end else if (result_update_i) begin
      p3v_r  <= port3_pin_voltage_count_i;
      p4i_r  <= port4_current_count_i;
      p4v_r  <= port4_pin_voltage_count_i;
      vin_r  <= supply_voltage_count_i;
      temp_r <= die_temperature_count_i;
    end
  end

  assign die_identification_w[`MRR_ID_SITE_HI:`MRR_ID_SITE_LO]   = SITE_CODE;
  assign die_identification_w[`MRR_ID_MAJOR_HI:`MRR_ID_MAJOR_LO] = MAJOR_REVISION;
  assign die_identification_w[`MRR_ID_MINOR_HI:`MRR_ID_MINOR_LO] = MINOR_REVISION;
  assign die_identification_w[`MRR_ID_MAKER_HI:`MRR_ID_MAKER_LO] = MAKER_CODE;

  // Writes are accepted and ignored; the power-limit pair stays latched.
  always @* begin
    rdata_nxt = `MRR_DATA_RST;
    if (reg_addr_i == `MRR_ADDR_P3V_LO) begin
      rdata_nxt = low_byte(p3v_r);
    end else if (reg_addr_i == `MRR_ADDR_P3V_HI) begin
      rdata_nxt = high_byte(p3v_r);
    end else if (reg_addr_i == `MRR_ADDR_P4I_LO) begin
      rdata_nxt = low_byte(p4i_r);
    end else if (reg_addr_i == `MRR_ADDR_P4I_HI) begin
      rdata_nxt = high_byte(p4i_r);
    end else if (reg_addr_i == `MRR_ADDR_P4V_LO) begin
      rdata_nxt = low_byte(p4v_r);
    end else if (reg_addr_i == `MRR_ADDR_P4V_HI) begin
      rdata_nxt = high_byte(p4v_r);
    end else if (reg_addr_i == `MRR_ADDR_VIN_LO) begin
      rdata_nxt = low_byte(vin_r);
    end else if (reg_addr_i == `MRR_ADDR_VIN_HI) begin
      rdata_nxt = high_byte(vin_r);
    end else if (reg_addr_i == `MRR_ADDR_TEMP_LO) begin
      rdata_nxt = low_byte(temp_r);
    end else if (reg_addr_i == `MRR_ADDR_TEMP_HI) begin
      rdata_nxt = high_byte(temp_r);
    end else if (reg_addr_i == `MRR_ADDR_PWR_LO) begin
      rdata_nxt = low_byte(pwr_w);
    end else if (reg_addr_i == `MRR_ADDR_PWR_HI) begin
      rdata_nxt = high_byte(pwr_w);
    end else if (reg_addr_i == `MRR_ADDR_DIE_IDENTIFICATION) begin
      rdata_nxt = die_identification_w;
    end
  end

  // Read data stand only in the cycle after the strobe.
  always @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      reg_rdata_o <= `MRR_DATA_RST;
    end else if (reg_read_i) begin
      reg_rdata_o <= rdata_nxt;
    end else begin
      reg_rdata_o <= `MRR_DATA_RST;
    end
  end
endmodule // mrr_measurement_regs
`default_nettype wire

// >>> hw/mrr_power_latch.v
// Capture of the power-limit count once after reset release.
`default_nettype none
`include "mrr_consts.vh"
module mrr_power_latch #(
  parameter WIDTH = 9
) (
  input  wire             core_clk_i,
  input  wire             reset_i,
  input  wire [WIDTH-1:0] power_limit_count_i,
  output reg  [WIDTH-1:0] power_limit_count_o
);
  reg captured_r;

  // The count is taken at the first edge after reset release and then frozen.
  always @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      captured_r          <= 1'b0;
      power_limit_count_o <= {WIDTH{1'b0}};
    end else if (!captured_r) begin
      captured_r          <= 1'b1;
      power_limit_count_o <= power_limit_count_i;
    end
  end
endmodule // mrr_power_latch
`default_nettype wire

// >>> inc/mrr_consts.vh
// Register offsets, field positions and reset values of the measurement result bank.
`ifndef MRR_CONSTS_VH
`define MRR_CONSTS_VH
`define MRR_ADDR_P3V_LO    8'h4a
`define MRR_ADDR_P3V_HI    8'h4b
`define MRR_ADDR_P4I_LO    8'h4c
`define MRR_ADDR_P4I_HI    8'h4d
`define MRR_ADDR_P4V_LO    8'h4e
`define MRR_ADDR_P4V_HI    8'h4f
`define MRR_ADDR_VIN_LO    8'h50
`define MRR_ADDR_VIN_HI    8'h51
`define MRR_ADDR_TEMP_LO   8'h52
`define MRR_ADDR_TEMP_HI   8'h53
`define MRR_ADDR_PWR_LO    8'h54
`define MRR_ADDR_PWR_HI    8'h55
`define MRR_ADDR_DIE_IDENTIFICATION    8'h60
`define MRR_COUNT_W        9
`define MRR_COUNT_RST      9'h000
`define MRR_DATA_RST       8'h00
`define MRR_ID_SITE_HI     7
`define MRR_ID_SITE_LO     6
`define MRR_ID_MAJOR_HI    5
`define MRR_ID_MAJOR_LO    4
`define MRR_ID_MINOR_HI    3
`define MRR_ID_MINOR_LO    2
`define MRR_ID_MAKER_HI    1
`define MRR_ID_MAKER_LO    0
`endif

// >>> verification/mrr_regs_sva.sv
// Read port checks of the measurement result bank.
`default_nettype none
module mrr_regs_sva #(
  parameter [1:0] SITE_CODE      = 2'h1,
  parameter [1:0] MAJOR_REVISION = 2'h1,
  parameter [1:0] MINOR_REVISION = 2'h1,
  parameter [1:0] MAKER_CODE     = 2'h2
) (
  input wire logic       core_clk_i,
  input wire logic       reset_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic       reg_read_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic [8:0] port3_pin_voltage_count_i,
  input wire logic [8:0] port4_current_count_i,
  input wire logic [8:0] port4_pin_voltage_count_i,
  input wire logic [8:0] supply_voltage_count_i,
  input wire logic [8:0] die_temperature_count_i,
  input wire logic [8:0] power_limit_count_i,
  input wire logic       result_update_i
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [8:0] pw_r;
  logic       armed_r;
  // Mirrors the one-time capture of the power count after reset.
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      armed_r <= 1'b0;
      pw_r    <= 9'h000;
    end else if (!armed_r) begin
      armed_r <= 1'b1;
      pw_r    <= power_limit_count_i;
    end
  end
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (reset_i);
  sequence rd_s(logic [7:0] a);
    reg_read_i && reg_addr_i == a && $past(result_update_i);
  endsequence
  a_p3v_high: assert property (
    rd_s(8'h4b) |=> reg_rdata_o == 8'($past(port3_pin_voltage_count_i, 2) >> 1)) else $error("p3v");
  a_p4i_low: assert property (
    rd_s(8'h4c) |=> reg_rdata_o == {7'h00, $past(port4_current_count_i[0], 2)}) else $error("p4i");
  a_p4v_high: assert property (
    rd_s(8'h4f) |=> reg_rdata_o == 8'($past(port4_pin_voltage_count_i, 2) >> 1)) else $error("p4v");
  a_vin_low: assert property (
    rd_s(8'h50) |=> reg_rdata_o == {7'h00, $past(supply_voltage_count_i[0], 2)}) else $error("vin");
  a_temp_high: assert property (
    rd_s(8'h53) |=> reg_rdata_o == 8'($past(die_temperature_count_i, 2) >> 1)) else $error("temp");
  a_pwr_high: assert property (
    reg_read_i && reg_addr_i == 8'h55 && armed_r |=> reg_rdata_o == 8'(pw_r >> 1)) else $error("pwr");
  a_pwr_low: assert property (
    reg_read_i && reg_addr_i == 8'h54 && armed_r |=> reg_rdata_o == {7'h00, pw_r[0]}) else $error("pwl");
  a_die_identification: assert property (
    reg_read_i && reg_addr_i == 8'h60 |=> reg_rdata_o
      == {SITE_CODE, MAJOR_REVISION, MINOR_REVISION, MAKER_CODE}) else $error("id");
endmodule // mrr_regs_sva
bind mrr_measurement_regs mrr_regs_sva #(.SITE_CODE(SITE_CODE), .MAJOR_REVISION(MAJOR_REVISION),
  .MINOR_REVISION(MINOR_REVISION), .MAKER_CODE(MAKER_CODE)) u_sva (.core_clk_i, .reset_i,
  .reg_addr_i, .reg_read_i, .reg_rdata_o, .port3_pin_voltage_count_i, .port4_current_count_i,
  .port4_pin_voltage_count_i, .supply_voltage_count_i, .die_temperature_count_i,
  .power_limit_count_i, .result_update_i);
`default_nettype wire

// >>> verification/mrr_testbench.sv
// Self-checking bench of the measurement result bank.
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic       core_clk_i = 1'b0;
  logic       reset_i = 1'b1;
  logic       reg_write_i = 1'b0;
  logic       reg_read_i = 1'b0;
  logic       result_update_i = 1'b0;
  logic [7:0] reg_addr_i = 8'h00;
  logic [7:0] reg_wdata_i = 8'h00;
  logic [7:0] reg_rdata_o;
  logic [8:0] cnt [6] = '{9'h0, 9'h0, 9'h0, 9'h0, 9'h0, 9'h16b};
  int         errors = 0;
  int         total_checks = 0;
  always #10 core_clk_i = ~core_clk_i;
  mrr_measurement_regs i_mrr_measurement_regs (.core_clk_i, .reset_i, .reg_addr_i,
    .reg_wdata_i, .reg_write_i, .reg_read_i, .reg_rdata_o, .result_update_i,
    .port3_pin_voltage_count_i(cnt[0]), .port4_current_count_i(cnt[1]),
    .port4_pin_voltage_count_i(cnt[2]), .supply_voltage_count_i(cnt[3]),
    .die_temperature_count_i(cnt[4]), .power_limit_count_i(cnt[5]));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge core_clk_i);
    reg_read_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge core_clk_i);
    reg_read_i <= 1'b0;
    #1 chk(reg_rdata_o, exp);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    reg_write_i <= 1'b1;
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    @(posedge core_clk_i);
    reg_write_i <= 1'b0;
  endtask
  task automatic test_results();
    for (int i = 0; i < 5; i++) begin
      cnt[i] <= 9'(9'h155 ^ (i * 9'h0a3));
    end
    result_update_i <= 1'b1;
    @(posedge core_clk_i);
    for (int i = 0; i < 5; i++) begin
      rd(8'(8'h4a + 2 * i), {7'h00, cnt[i][0]});
      rd(8'(8'h4b + 2 * i), cnt[i][8:1]);
    end
    result_update_i <= 1'b0;
    cnt[0] <= 9'h0aa;
    wr(8'h4b, 8'hff);
    rd(8'h4b, 8'haa);
  endtask
  task automatic test_power();
    rd(8'h55, 8'hb5);
    cnt[5] <= 9'h0b4;
    wr(8'h55, 8'h00);
    rd(8'h54, 8'h01);
    @(posedge core_clk_i);
    reset_i <= 1'b1;
    @(posedge core_clk_i);
    reset_i <= 1'b0;
    rd(8'h55, 8'h5a);
  endtask
  task automatic test_id();
    rd(8'h60, 8'h56);
    rd(8'h61, 8'h00);
  endtask
  task automatic stop_test();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge core_clk_i);
    reset_i <= 1'b0;
    test_power();
    test_results();
    test_id();
    stop_test();
  end
endmodule // testbench
`default_nettype wire
